// file: logic/lvd_control.sv
// Our own choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none

// Contract
// (R01) enable bit at bit 7 turns the comparator and detection logic on.
// (R02) bit 1 picks interrupt on both crossings or reset on falling below.
// (R03) read-only flag at bit 0 shows supply below threshold while enabled.
// (R04) control resets to 82H after detector reset, 00H after others.
// (R05) enable plus reset mode lock control and level until other reset.
// (R06) a detector reset sets the low-voltage flag in the reset source.
// (R07) control writes only count after the protected unlock write.
// (R08) control is byte/bit accessible with flag read-only; level byte only.
// (R09) software writes zero to control bits 6 to 2.
// (R10) level bit 0 picks 2.80 V or 2.30 V and drives the comparator.
// (R11) level select keeps its value over detector reset, else clears.
// (R12) software writes zero to level select bits 7 to 1.
// (R13) software waits 0.2 ms after enabling before trusting the flag.
// (R14) software keeps enable set while the flag reads one.
// (R15) reset mode arm: mask, level, enable, wait, check flag, set mode.
// (R16) interrupt arm: mask, level, enable, wait, check, clear, unmask.
// (R17) stop interrupt mode only after the flag shows supply above.
// (R18) on interrupt software reads the flag to learn the direction.
// (R19) detection, interrupt and reset keep working in standby.
// (R20) comparator synchronised; edge pulses interrupt; low holds reset.
module lvd_control (
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        supplyBelow,
  output logic             cmpEnable,
  output logic             levelSelect,
  output logic             lowVoltInterrupt,
  output logic             lowVoltReset
);

  // synchronised comparator level
  logic belowSync;

  lvd_sync u_sync (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .asyncIn (supplyBelow),
    .syncOut (belowSync)
  );

  // register state
  logic                   enable_r;
  logic                   enable_nxt;
  logic                   mode_r;
  logic                   mode_nxt;
  logic                   flag_r;
  logic                   flag_nxt;
  logic                   level_r;
  logic                   level_nxt;
  logic                   unlocked_r;
  logic                   unlocked_nxt;
  logic                   lvrFlag_r;
  logic                   lvrFlag_nxt;
  logic                   prevBelow_r;
  logic                   prevBelow_nxt;
  logic                   irq_r;
  logic                   irq_nxt;
  logic                   rstReq_r;
  logic                   rstReq_nxt;
  lvd_pkg::lvd_state_type state_r;
  lvd_pkg::lvd_state_type state_nxt;

  // bus state
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic        pready_r;
  logic        pready_nxt;
  logic        pslverr_r;
  logic        pslverr_nxt;

  // decode helpers
  logic hitControl;
  logic hitLevel;
  logic hitUnlock;
  logic hitRstSrc;
  logic mapped;
  logic accessDone;
  logic wrDone;
  logic locked;

  function automatic logic hit(input logic [31:0] addr,
                               input logic [31:0] idx);
    hit = (addr == lvd_pkg::byte_addr(idx));
  endfunction

  always_comb begin
    hitControl = hit(paddr, lvd_pkg::IDX_CONTROL);
    hitLevel   = hit(paddr, lvd_pkg::IDX_LEVEL);
    hitUnlock  = hit(paddr, lvd_pkg::IDX_UNLOCK);
    hitRstSrc  = hit(paddr, lvd_pkg::IDX_RSTSRC);
    mapped     = hitControl | hitLevel | hitUnlock | hitRstSrc;
    // a transfer completes at the edge where pready is seen high
    accessDone = psel & penable & pready_r;
    wrDone     = accessDone & pwrite & mapped & pstrb[0];
    locked     = enable_r & mode_r; // (R05)
  end

  // detector state and register file
  always_comb begin
    enable_nxt    = enable_r;
    mode_nxt      = mode_r;
    level_nxt     = level_r;
    unlocked_nxt  = unlocked_r;
    lvrFlag_nxt   = lvrFlag_r;
    prevBelow_nxt = belowSync;
    irq_nxt       = 1'b0;
    rstReq_nxt    = 1'b0;
    state_nxt     = state_r;

    // the unlock key arms exactly one following write
    if (wrDone) begin
      unlocked_nxt = hitUnlock &
                     (pwdata[7:0] == lvd_pkg::UNLOCK_KEY); // (R07)
    end

    // software updates; a locked detector ignores both registers
    if (wrDone && hitControl && unlocked_r && !locked) begin // (R07)
      enable_nxt = pwdata[lvd_pkg::CTL_ENABLE_BIT]; // (R01) (R08)
      mode_nxt   = pwdata[lvd_pkg::CTL_MODE_BIT];   // (R02)
    end
    if (wrDone && hitLevel && !locked) begin // (R05)
      level_nxt = pwdata[lvd_pkg::LVL_SEL_BIT]; // (R10) (R08)
    end
    // flag clears on a write of one; a new detector reset wins
    if (wrDone && hitRstSrc && pwdata[lvd_pkg::RSRC_LVR_BIT]) begin
      lvrFlag_nxt = 1'b0;
    end

    unique case (state_r)
      lvd_pkg::LVD_IDLE: begin
        if (enable_r) begin
          state_nxt = lvd_pkg::LVD_DETECT;
        end
      end
      lvd_pkg::LVD_DETECT: begin
        // no clock gating here, so standby does not stop detection
        if (!enable_r) begin // (R19)
          state_nxt = lvd_pkg::LVD_IDLE;
        end else if (mode_r && belowSync) begin
          state_nxt = lvd_pkg::LVD_RESET; // (R02)
        end else if (!mode_r && (belowSync != prevBelow_r)) begin
          irq_nxt = 1'b1; // (R02) (R20)
        end
      end
      lvd_pkg::LVD_RESET: begin
        // detector reset: control forced to its detector reset value,
        // level select left as it was
        enable_nxt  = lvd_pkg::CTL_RST_DETECTOR[lvd_pkg::CTL_ENABLE_BIT];
        mode_nxt    = lvd_pkg::CTL_RST_DETECTOR[lvd_pkg::CTL_MODE_BIT];
        // (R04) (R11)
        lvrFlag_nxt = 1'b1; // (R06)
        rstReq_nxt  = belowSync; // (R20)
        if (!belowSync) begin
          state_nxt = lvd_pkg::LVD_DETECT;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      // any reset other than the detector's clears everything
      enable_r    <= lvd_pkg::CTL_RST_OTHER[lvd_pkg::CTL_ENABLE_BIT];
      mode_r      <= lvd_pkg::CTL_RST_OTHER[lvd_pkg::CTL_MODE_BIT];
      // (R04)
      level_r     <= lvd_pkg::LVL_RST_OTHER[lvd_pkg::LVL_SEL_BIT]; // (R11)
      unlocked_r  <= 1'b0;
      lvrFlag_r   <= 1'b0;
      prevBelow_r <= 1'b0;
      irq_r       <= 1'b0;
      rstReq_r    <= 1'b0;
      state_r     <= lvd_pkg::LVD_IDLE;
    end else begin
      enable_r    <= enable_nxt;
      mode_r      <= mode_nxt;
      level_r     <= level_nxt;
      unlocked_r  <= unlocked_nxt;
      lvrFlag_r   <= lvrFlag_nxt;
      prevBelow_r <= prevBelow_nxt;
      irq_r       <= irq_nxt;
      rstReq_r    <= rstReq_nxt;
      state_r     <= state_nxt;
    end
  end

  // below-threshold flag; reads zero while detection is off
  always_comb begin
    flag_nxt = enable_r & belowSync; // (R03)
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      flag_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  // APB slave: one wait state, answer registered
  always_comb begin
    prdata_nxt  = prdata_r;
    pready_nxt  = 1'b0;
    pslverr_nxt = 1'b0;
    if (psel && penable && !pready_r) begin
      pready_nxt  = 1'b1;
      pslverr_nxt = !mapped;
      prdata_nxt  = 32'h0;
      if (!pwrite) begin
        if (hitControl) begin
          // flag bit is read-only; bits 6 to 2 read zero
          prdata_nxt[lvd_pkg::CTL_ENABLE_BIT] = enable_r;
          prdata_nxt[lvd_pkg::CTL_MODE_BIT]   = mode_r;
          prdata_nxt[lvd_pkg::CTL_FLAG_BIT]   = flag_r; // (R03)
        end else if (hitLevel) begin
          prdata_nxt[lvd_pkg::LVL_SEL_BIT] = level_r;
        end else if (hitUnlock) begin
          prdata_nxt[0] = unlocked_r;
        end else if (hitRstSrc) begin
          prdata_nxt[lvd_pkg::RSRC_LVR_BIT] = lvrFlag_r;
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      prdata_r  <= 32'h0;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      prdata_r  <= prdata_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  assign prdata           = prdata_r;
  assign pready           = pready_r;
  assign pslverr          = pslverr_r;
  assign cmpEnable        = enable_r;  // (R01)
  assign levelSelect      = level_r;   // (R10)
  assign lowVoltInterrupt = irq_r;     // (R02)
  assign lowVoltReset     = rstReq_r;  // (R02)

endmodule

`default_nettype wire

// file: logic/lvd_pkg.sv
package lvd_pkg;

  // register indices; byte address is four times the index
  localparam logic [31:0] IDX_CONTROL = 32'hfffff890;
  localparam logic [31:0] IDX_LEVEL   = 32'hfffff891;
  localparam logic [31:0] IDX_UNLOCK  = 32'hfffff892;
  localparam logic [31:0] IDX_RSTSRC  = 32'hfffff893;

  // control register fields
  localparam int CTL_ENABLE_BIT = 7;
  localparam int CTL_MODE_BIT   = 1;
  localparam int CTL_FLAG_BIT   = 0;
  // level select field
  localparam int LVL_SEL_BIT    = 0;
  // reset source field
  localparam int RSRC_LVR_BIT   = 0;

  // control value after a detector reset and after any other reset; level value after any other reset
  localparam logic [7:0] CTL_RST_DETECTOR = 8'h82;
  localparam logic [7:0] CTL_RST_OTHER    = 8'h00;
  localparam logic [7:0] LVL_RST_OTHER    = 8'h00;

  // byte that the unlock register expects before a control write
  localparam logic [7:0] UNLOCK_KEY = 8'ha5;

  typedef enum logic [1:0] {
    LVD_IDLE,
    LVD_DETECT,
    LVD_RESET
  } lvd_state_type;

  function automatic logic [31:0] byte_addr(input logic [31:0] idx);
    byte_addr = {idx[29:0], 2'h0};
  endfunction

endpackage

// file: logic/lvd_sync.sv
`timescale 1ns/1ps
`default_nettype none

module lvd_sync (
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  input  wire logic asyncIn,
  output logic      syncOut
);

  logic stage1_r;
  logic stage1_nxt;
  logic stage2_r;
  logic stage2_nxt;

  always_comb begin
    stage1_nxt = asyncIn;
    stage2_nxt = stage1_r;
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      stage1_r <= 1'b0;
      stage2_r <= 1'b0;
    end else begin
      stage1_r <= stage1_nxt;
      stage2_r <= stage2_nxt;
    end
  end

  assign syncOut = stage2_r;

endmodule

`default_nettype wire

// file: sim/lvd_cmp_model.sv
`timescale 1ns/1ps
`default_nettype none

module lvd_cmp_model (
  input  wire logic        cmpEnable,
  input  wire logic        levelSelect,
  input  wire logic [15:0] supplyMv,
  output logic             supplyBelow
);
  // a disabled comparator parks low, so a stale level never leaks out
  always_comb supplyBelow = cmpEnable &&
    (supplyMv < (levelSelect ? 16'd2300 : 16'd2800));
endmodule

`default_nettype wire

// file: sim/lvd_control_assertions.sv
`timescale 1ns/1ps
`default_nettype none

module lvd_control_assertions (
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        supplyBelow,
  input wire logic        cmpEnable,
  input wire logic        levelSelect,
  input wire logic        lowVoltInterrupt,
  input wire logic        lowVoltReset
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  logic       prev_r;
  logic [3:0] age_r;
  logic [3:0] age_nxt;
  // cycles since the comparator pin last changed, saturating
  always_comb begin
    age_nxt = (age_r == 4'hf) ? age_r : age_r + 4'h1;
    if (supplyBelow != prev_r) age_nxt = 4'h0;
  end
  always_ff @(posedge sys_clk) begin
    prev_r <= supplyBelow;
    age_r  <= sys_rst ? 4'hf : age_nxt;
  end
  AST_PREADY_PULSE: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  AST_PREADY_TIME: assert property ($rose(penable) && psel |=> pready)
    else $error("ready late");
  AST_SLVERR_READY: assert property (pslverr |-> pready)
    else $error("error without ready");
  AST_IRQ_PULSE: assert property (lowVoltInterrupt |=> !lowVoltInterrupt)
    else $error("interrupt longer than one cycle");
  AST_IRQ_CAUSE: assert property (lowVoltInterrupt |-> age_r <= 4'h6)
    else $error("interrupt without pin change");
  AST_EVENT_ENABLED: assert property (lowVoltInterrupt || lowVoltReset |-> cmpEnable)
    else $error("event while disabled");
  AST_RESET_DROPS: assert property (!supplyBelow [*6] |-> !lowVoltReset)
    else $error("reset held with supply above");
  AST_RESET_LOCK: assert property (lowVoltReset |=> cmpEnable && $stable(levelSelect))
    else $error("settings moved under reset");
  AST_OTHER_RESET: assert property ($fell(sys_rst) |-> !cmpEnable && !levelSelect)
    else $error("outputs not cleared by reset");
  cover property (lowVoltInterrupt);
  cover property ($rose(lowVoltReset));
  cover property (pslverr);
endmodule

`default_nettype wire

// file: sim/low_voltage_detect_control_tb.sv
`timescale 1ns/1ps
`default_nettype none

module low_voltage_detect_control_tb;
  localparam logic [31:0] A_CTL = lvd_pkg::IDX_CONTROL << 2;
  localparam logic [31:0] A_LVL = lvd_pkg::IDX_LEVEL << 2;
  localparam logic [31:0] A_UNL = lvd_pkg::IDX_UNLOCK << 2;
  localparam logic [31:0] A_SRC = lvd_pkg::IDX_RSTSRC << 2;
  logic        sys_clk, sys_rst, psel, penable, pwrite, pready, pslverr;
  logic        supplyBelow, cmpEnable, levelSelect;
  logic        lowVoltInterrupt, lowVoltReset, lastErr;
  logic [31:0] paddr, pwdata, prdata;
  logic [3:0]  pstrb;
  logic [15:0] supplyMv;
  logic [31:0] expQ[$];
  int          fails, num_checks, seed, irqCount;

  lvd_control u_lvd_control (.sys_clk, .sys_rst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .supplyBelow,
    .cmpEnable, .levelSelect, .lowVoltInterrupt, .lowVoltReset);
  lvd_cmp_model u_lvd_cmp_model (.cmpEnable, .levelSelect, .supplyMv,
    .supplyBelow);

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic print_verdict;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // holds the request until ready is sampled, then idles one cycle
  task automatic apb(input logic w, input logic [31:0] a, input logic [7:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'($random(seed)), d};
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge sys_clk);
      n++;
    end
    if (n == 20) fails++;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic rd(input logic [31:0] a, input logic [7:0] e);
    expQ.push_back({24'h0, e});
    apb(1'b0, a, 8'h0);
  endtask

  task automatic ulw(input logic [7:0] d);
    apb(1'b1, A_UNL, lvd_pkg::UNLOCK_KEY);
    apb(1'b1, A_CTL, d);
  endtask

  task automatic setMv(input logic [15:0] base);
    supplyMv <= base + 16'($random(seed) & 32'h1ff);
    repeat (10) @(posedge sys_clk);
  endtask

  always @(posedge sys_clk) begin
    if (pready === 1'b1 && pwrite === 1'b0 && expQ.size() > 0)
      chk("read data", expQ.pop_front(), prdata);
    if (lowVoltInterrupt === 1'b1) irqCount++;
  end

  initial begin
    // the comparator settling wait alone takes 4000 cycles
    #(50 * 20000);
    fails++;
    print_verdict;
  end

  initial begin
    {fails, num_checks, irqCount} = '0;
    seed = 45355;
    {sys_rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 67'h0};
    pstrb = 4'hf;
    supplyMv = 16'd3300;
    repeat (20) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    rd(A_CTL, lvd_pkg::CTL_RST_OTHER);
    rd(A_LVL, lvd_pkg::LVL_RST_OTHER);
    apb(1'b1, A_CTL + 32'h40, 8'h0);
    chk("slave error", 32'h1, {31'h0, lastErr});
    apb(1'b1, A_CTL, 8'h80);
    rd(A_CTL, 8'h00);
    // level is chosen before detection is switched on
    apb(1'b1, A_LVL, 8'h01);
    pstrb <= 4'he;
    apb(1'b1, A_LVL, 8'h00);
    pstrb <= 4'hf;
    rd(A_LVL, 8'h01);
    chk("level", 32'h1, {31'h0, levelSelect});
    ulw(8'h80);
    // 0.2 ms of comparator settling at 50 ns per cycle
    repeat (4000) @(posedge sys_clk);
    rd(A_CTL, 8'h80);
    chk("enable", 32'h1, {31'h0, cmpEnable});
    setMv(16'd1500);
    chk("irq fall", 32'h1, 32'(irqCount));
    rd(A_CTL, 8'h81);
    setMv(16'd2850);
    chk("irq rise", 32'h2, 32'(irqCount));
    rd(A_CTL, 8'h80);
    ulw(8'h82);
    rd(A_CTL, 8'h82);
    apb(1'b1, A_LVL, 8'h00);
    rd(A_LVL, 8'h01);
    setMv(16'd1500);
    chk("reset req", 32'h1, {31'h0, lowVoltReset});
    chk("no irq", 32'h2, 32'(irqCount));
    setMv(16'd2850);
    chk("reset gone", 32'h0, {31'h0, lowVoltReset});
    rd(A_CTL, lvd_pkg::CTL_RST_DETECTOR);
    rd(A_LVL, 8'h01);
    rd(A_SRC, 8'h01);
    apb(1'b1, A_SRC, 8'h01);
    rd(A_SRC, 8'h00);
    sys_rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    rd(A_CTL, 8'h00);
    rd(A_LVL, 8'h00);
    print_verdict;
  end
endmodule

bind lvd_control lvd_control_assertions u_lvd_control_assertions (.sys_clk,
  .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
  .pready, .pslverr, .supplyBelow, .cmpEnable, .levelSelect,
  .lowVoltInterrupt, .lowVoltReset);

`default_nettype wire
